// ### core/comm_watchdog.sv
`timescale 1ns/100ps
module comm_watchdog #(
  parameter int TIMEOUT_CYCLES = servo_io_pkg::WDOG_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // activity
  input wire logic kick,
  output logic alive,
  output logic expired
);
  import servo_io_pkg::*;

  localparam logic [WDOG_CNT_W-1:0] LAST = WDOG_CNT_W'(TIMEOUT_CYCLES - 1);

  logic [WDOG_CNT_W-1:0] cnt_r;
  logic alive_r;
  logic expired_r;

  // dead until the first kick, so power-up counts as a timeout
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_r <= '0;
      alive_r <= 1'b0;
      expired_r <= 1'b0;
    end
    else
    begin
      expired_r <= 1'b0;
      if (kick)
      begin
        cnt_r <= '0;
        alive_r <= 1'b1;
      end
      else if (alive_r)
      begin
        if (cnt_r == LAST)
        begin
          alive_r <= 1'b0;
          expired_r <= 1'b1;
        end
        else
        begin
          cnt_r <= cnt_r + 1'b1;
        end
      end
    end
  end

  assign alive = alive_r;
  assign expired = expired_r;
endmodule : comm_watchdog

// ### core/encoder_mux.sv
`timescale 1ns/100ps
module encoder_mux (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // encoder receivers
  input servo_io_pkg::enc_lines_t enc_pos,
  input servo_io_pkg::enc_lines_t enc_neg,
  input wire logic [servo_io_pkg::N_AXIS-1:0] differential,
  // host side
  input wire logic mux_select,
  output servo_io_pkg::muxed_lines_t muxed
);
  import servo_io_pkg::*;

  // a floating negative line would corrupt diff mode, so single-ended ignores it
  function automatic logic [N_AXIS-1:0] receive(input logic [N_AXIS-1:0] pos,
                                                input logic [N_AXIS-1:0] neg,
                                                input logic [N_AXIS-1:0] diff);
    receive = (diff & pos & ~neg) | (~diff & pos); // RQ6
  endfunction : receive

  function automatic logic [N_PAIR-1:0] pick(input logic [N_AXIS-1:0] v, input logic sel);
    logic [N_PAIR-1:0] r;
    r = '0;
    for (int k = 0; k < N_PAIR; k++)
    begin
      r[k] = sel ? v[2*k+1] : v[2*k]; // RQ18
    end
    pick = r;
  endfunction : pick

  muxed_lines_t muxed_r;

  // registered so lines settle one clock after a select change
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      muxed_r <= '0;
    end
    else
    begin
      muxed_r.phase_a <= pick(receive(enc_pos.phase_a, enc_neg.phase_a, differential), mux_select); // RQ7
      muxed_r.phase_b <= pick(receive(enc_pos.phase_b, enc_neg.phase_b, differential), mux_select); // RQ5
      muxed_r.index <= pick(receive(enc_pos.index, enc_neg.index, differential), mux_select); // RQ16
    end
  end

  assign muxed = muxed_r;
endmodule : encoder_mux

// ### core/servo_io_pkg.sv
// How it works
// [RQ1] at power-up analog outputs are zero and drive enables open until host talks
// [RQ2] over 50 ms without analog access: outputs to zero, enables open
// [RQ3] six signed analog command channels, full scale mapped to plus/minus ten volts
// [RQ4] enables 0..4 share one control bit, enable 5 has its own bit
// [RQ5] six encoder channels, each with phase a, phase b and index
// [RQ6] per-channel differential or single-ended reception, single-ended uses positive lines
// [RQ7] encoders time-multiplexed toward host, host toggles select at slow clock over 8
// [RQ8] host resolves counts at half the multiplex rate
// [RQ9] host keeps multiplex rate at or below about 12 MHz
// [RQ10] field fault indicator lit from power-up until host communication established
// [RQ11] activity indicator toggles about 1 Hz at 1 kHz updates; fault off when running
// [RQ12] field section samples 32 inputs and drives 16 outputs for the host
// [RQ13] field supply too high or too low raises a field fault
// [RQ14] field section answers and works only while its logic supply is present
// [RQ15] host provides step, encoder and serial channels carrying field traffic
// [RQ16] host drives mux select; device drives muxed encoder lines back
// [RQ17] after any field fault output updates are ignored until host clears it
// [RQ18] each muxed line carries two encoders, one per select level
package servo_io_pkg;
  localparam int CLK_HZ = 25_000_000;
  localparam int WDOG_MS = 50;
  localparam longint WDOG_PRODUCT = longint'(WDOG_MS) * longint'(CLK_HZ);
  localparam int WDOG_CYCLES = int'(WDOG_PRODUCT / 1000);
  localparam int WDOG_CNT_W = 21;
  // half of 1000 updates per blink period
  localparam logic [9:0] ACT_TOGGLE_COUNT = 10'h1f4;
  localparam int N_AXIS = 6;
  localparam int N_PAIR = 3;

  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;
  localparam logic [7:0] OFS_CMD0 = 8'h10;
  localparam logic [7:0] OFS_CMD5 = 8'h24;
  localparam logic [7:0] OFS_FIELD_OUT = 8'h28;
  localparam logic [7:0] OFS_FIELD_IN = 8'h2c;
  localparam logic [7:0] OFS_ENC_MODE = 8'h30;

  localparam int CTRL_AXIS_EN_BIT = 0;
  localparam int CTRL_SPINDLE_EN_BIT = 1;
  localparam int CTRL_FAULT_CLR_BIT = 2;
  localparam int IRQ_ANALOG_TRIP_BIT = 0;
  localparam int IRQ_FIELD_FAULT_BIT = 1;
  localparam int IRQ_SUPPLY_BIT = 2;

  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
  localparam logic [5:0] ENC_MODE_RESET = 6'h3f;
  localparam logic signed [15:0] CMD_ZERO = 16'sh0000;

  typedef logic signed [15:0] cmd_word_t;
  typedef cmd_word_t [N_AXIS-1:0] cmd_bank_t;

  typedef struct packed {
    logic [N_AXIS-1:0] phase_a;
    logic [N_AXIS-1:0] phase_b;
    logic [N_AXIS-1:0] index;
  } enc_lines_t;

  typedef struct packed {
    logic [N_PAIR-1:0] phase_a;
    logic [N_PAIR-1:0] phase_b;
    logic [N_PAIR-1:0] index;
  } muxed_lines_t;

  typedef enum {FLD_FAULT, FLD_RUN} field_state_t;
endpackage : servo_io_pkg

// ### core/servo_io_watchdog_encoder_mux.sv
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
module servo_io_watchdog_encoder_mux #(
  parameter int ANALOG_WDOG_CYCLES = servo_io_pkg::WDOG_CYCLES,
  parameter int FIELD_WDOG_CYCLES = servo_io_pkg::WDOG_CYCLES
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic RESET,
  // register port
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  output logic IRQ,
  // analog drive
  output servo_io_pkg::cmd_bank_t ANALOG_COMMAND_OUTPUT,
  output logic [4:0] DRIVE_ENABLE_SWITCH,
  output logic SPINDLE_DRIVE_ENABLE,
  // encoders
  input servo_io_pkg::enc_lines_t ENCODER_POS,
  input servo_io_pkg::enc_lines_t ENCODER_NEG,
  input wire logic ENCODER_MUX_SELECT,
  output servo_io_pkg::muxed_lines_t MUXED_ENCODER,
  // field io
  input wire logic [31:0] FIELD_INPUT,
  output logic [15:0] FIELD_OUTPUT,
  input wire logic FIELD_LOGIC_SUPPLY,
  input wire logic FIELD_SUPPLY_LOW,
  input wire logic FIELD_SUPPLY_HIGH,
  output logic FIELD_ACTIVITY_INDICATOR,
  output logic FIELD_FAULT_INDICATOR,
  // serial link
  input wire logic SERIAL_CHAN0_RECEIVE,
  output logic SERIAL_CHAN0_TRANSMIT
);
  import servo_io_pkg::*;

  function automatic logic is_cmd(input logic [7:0] a);
    is_cmd = (a >= OFS_CMD0) && (a <= OFS_CMD5) && (a[1:0] == 2'h0);
  endfunction : is_cmd

  function automatic int cmd_index(input logic [7:0] a);
    cmd_index = int'((a - OFS_CMD0) >> 2);
  endfunction : cmd_index

  // register file
  logic [1:0] ctrl_r;
  logic [2:0] irq_status_r;
  logic [2:0] irq_status_nxt;
  logic [2:0] irq_mask_r;
  logic [5:0] enc_mode_r;
  cmd_bank_t cmd_r;
  logic [15:0] field_out_r;
  logic [31:0] field_in_r;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;

  // analog section
  logic analog_kick;
  logic analog_alive;
  logic analog_expired;
  cmd_bank_t analog_out_r;
  logic [4:0] axis_en_r;
  logic spindle_en_r;

  // field section
  field_state_t field_state_r;
  logic field_kick;
  logic field_expired;
  logic supply_bad;
  logic supply_bad_r;
  logic fault_clear;
  logic fault_set;
  logic field_access;
  logic [9:0] act_cnt_r;
  logic act_led_r;
  logic [15:0] field_drive_r;
  logic tx_r;

  assign supply_bad = FIELD_LOGIC_SUPPLY & (FIELD_SUPPLY_LOW | FIELD_SUPPLY_HIGH);
  // without logic supply the field section is invisible
  assign field_access = FIELD_LOGIC_SUPPLY & ((WR & (ADDR == OFS_FIELD_OUT)) | (RD & (ADDR == OFS_FIELD_IN))); // RQ14

  // any analog register write counts as host contact
  assign analog_kick = WR & (is_cmd(ADDR) | (ADDR == OFS_CTRL));
  assign field_kick = field_access; // RQ15

  comm_watchdog #(
    .TIMEOUT_CYCLES(ANALOG_WDOG_CYCLES)
  ) u_analog_wdog (
    .clk(MCLK),
    .rst(RESET),
    .kick(analog_kick),
    .alive(analog_alive),
    .expired(analog_expired)
  );

  comm_watchdog #(
    .TIMEOUT_CYCLES(FIELD_WDOG_CYCLES)
  ) u_field_wdog (
    .clk(MCLK),
    .rst(RESET),
    .kick(field_kick),
    .alive(),
    .expired(field_expired)
  );

  encoder_mux u_enc_mux (
    .clk(MCLK),
    .rst(RESET),
    .enc_pos(ENCODER_POS),
    .enc_neg(ENCODER_NEG),
    .differential(enc_mode_r),
    .mux_select(ENCODER_MUX_SELECT),
    .muxed(MUXED_ENCODER)
  );

  // control and enable bits
  always_ff @(posedge MCLK or posedge RESET)
  begin
    if (RESET)
    begin
      ctrl_r <= CTRL_RESET;
      irq_mask_r <= IRQ_MASK_RESET;
      enc_mode_r <= ENC_MODE_RESET;
    end
    else if (WR)
    begin
      case (ADDR)
        OFS_CTRL: ctrl_r <= WDATA[1:0];
        OFS_IRQ_MASK: irq_mask_r <= WDATA[2:0];
        OFS_ENC_MODE: enc_mode_r <= WDATA[5:0]; // RQ6
        default: ctrl_r <= ctrl_r;
      endcase
    end
  end

  // channel commands, signed full scale is plus or minus ten volts
  always_ff @(posedge MCLK or posedge RESET)
  begin
    if (RESET)
    begin
      cmd_r <= '0;
    end
    else if (WR && is_cmd(ADDR))
    begin
      cmd_r[cmd_index(ADDR)] <= cmd_word_t'(WDATA[15:0]); // RQ3
    end
  end

  // stored commands survive a trip but are not driven until contact resumes
  always_ff @(posedge MCLK or posedge RESET)
  begin
    if (RESET)
    begin
      analog_out_r <= '0; // RQ1
      axis_en_r <= 5'h00;
      spindle_en_r <= 1'b0;
    end
    else if (!analog_alive)
    begin
      analog_out_r <= '0; // RQ2
      axis_en_r <= 5'h00;
      spindle_en_r <= 1'b0;
    end
    else
    begin
      analog_out_r <= cmd_r;
      axis_en_r <= {5{ctrl_r[CTRL_AXIS_EN_BIT]}}; // RQ4
      spindle_en_r <= ctrl_r[CTRL_SPINDLE_EN_BIT]; // RQ4
    end
  end

  // field fault flag, set wins over a clear in the same cycle
  assign fault_clear = WR & (ADDR == OFS_CTRL) & WDATA[CTRL_FAULT_CLR_BIT] & FIELD_LOGIC_SUPPLY;
  assign fault_set = field_expired | supply_bad; // RQ13

  always_ff @(posedge MCLK or posedge RESET)
  begin
    if (RESET)
    begin
      field_state_r <= FLD_FAULT; // RQ10
    end
    else
    begin
      case (field_state_r)
        FLD_FAULT:
        begin
          if (fault_clear && !fault_set)
          begin
            field_state_r <= FLD_RUN; // RQ17
          end
        end
        FLD_RUN:
        begin
          if (fault_set)
          begin
            field_state_r <= FLD_FAULT;
          end
        end
        default: field_state_r <= FLD_FAULT;
      endcase
    end
  end

  // output image only accepts updates while running
  always_ff @(posedge MCLK or posedge RESET)
  begin
    if (RESET)
    begin
      field_out_r <= 16'h0000;
    end
    else if (field_access && WR && field_state_r == FLD_RUN && !fault_set)
    begin
      field_out_r <= WDATA[15:0]; // RQ17
    end
  end

  // drivers are off in fault, the image is kept for software to read back
  always_ff @(posedge MCLK or posedge RESET)
  begin
    if (RESET)
    begin
      field_drive_r <= 16'h0000;
    end
    else
    begin
      field_drive_r <= (field_state_r == FLD_RUN && FIELD_LOGIC_SUPPLY) ? field_out_r : 16'h0000; // RQ12
    end
  end

  always_ff @(posedge MCLK or posedge RESET)
  begin
    if (RESET)
    begin
      field_in_r <= 32'h0000_0000;
    end
    else
    begin
      field_in_r <= FIELD_LOGIC_SUPPLY ? FIELD_INPUT : 32'h0000_0000; // RQ12
    end
  end

  // blink from update count so the rate tracks the host loop
  always_ff @(posedge MCLK or posedge RESET)
  begin
    if (RESET)
    begin
      act_cnt_r <= 10'h000;
      act_led_r <= 1'b0;
    end
    else if (field_access && field_state_r == FLD_RUN)
    begin
      if (act_cnt_r == ACT_TOGGLE_COUNT - 10'h001)
      begin
        act_cnt_r <= 10'h000;
        act_led_r <= ~act_led_r; // RQ11
      end
      else
      begin
        act_cnt_r <= act_cnt_r + 10'h001;
      end
    end
  end

  // link presence: echo only while powered, idle high otherwise
  always_ff @(posedge MCLK or posedge RESET)
  begin
    if (RESET)
    begin
      tx_r <= 1'b1;
    end
    else
    begin
      tx_r <= FIELD_LOGIC_SUPPLY ? SERIAL_CHAN0_RECEIVE : 1'b1; // RQ14
    end
  end

  // sticky events, write one to clear
  always_comb
  begin
    irq_status_nxt = irq_status_r;
    if (WR && ADDR == OFS_IRQ_STATUS)
    begin
      irq_status_nxt = irq_status_r & ~WDATA[2:0];
    end
    if (analog_expired)
    begin
      irq_status_nxt[IRQ_ANALOG_TRIP_BIT] = 1'b1;
    end
    if (fault_set && field_state_r == FLD_RUN)
    begin
      irq_status_nxt[IRQ_FIELD_FAULT_BIT] = 1'b1;
    end
    if (supply_bad && !supply_bad_r)
    begin
      irq_status_nxt[IRQ_SUPPLY_BIT] = 1'b1;
    end
  end

  always_ff @(posedge MCLK or posedge RESET)
  begin
    if (RESET)
    begin
      irq_status_r <= 3'h0;
      supply_bad_r <= 1'b0;
    end
    else
    begin
      irq_status_r <= irq_status_nxt;
      supply_bad_r <= supply_bad;
    end
  end

  // read path, unmapped addresses return zero
  always_comb
  begin
    rdata_nxt = 32'h0000_0000;
    if (is_cmd(ADDR))
    begin
      rdata_nxt = {{16{cmd_r[cmd_index(ADDR)][15]}}, cmd_r[cmd_index(ADDR)]};
    end
    else
    begin
      case (ADDR)
        OFS_CTRL: rdata_nxt = {30'h0, ctrl_r};
        OFS_STATUS: rdata_nxt = {27'h0, FIELD_SUPPLY_HIGH, FIELD_SUPPLY_LOW, FIELD_LOGIC_SUPPLY,
                                 field_state_r == FLD_FAULT, analog_alive};
        OFS_IRQ_STATUS: rdata_nxt = {29'h0, irq_status_r};
        OFS_IRQ_MASK: rdata_nxt = {29'h0, irq_mask_r};
        OFS_FIELD_OUT: rdata_nxt = FIELD_LOGIC_SUPPLY ? {16'h0, field_out_r} : 32'h0000_0000;
        OFS_FIELD_IN: rdata_nxt = field_in_r;
        OFS_ENC_MODE: rdata_nxt = {26'h0, enc_mode_r};
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge MCLK or posedge RESET)
  begin
    if (RESET)
    begin
      rdata_r <= 32'h0000_0000;
    end
    else if (RD)
    begin
      rdata_r <= rdata_nxt;
    end
    else
    begin
      rdata_r <= 32'h0000_0000;
    end
  end

  assign RDATA = rdata_r;
  assign IRQ = |(irq_status_r & irq_mask_r);
  assign ANALOG_COMMAND_OUTPUT = analog_out_r;
  assign DRIVE_ENABLE_SWITCH = axis_en_r;
  assign SPINDLE_DRIVE_ENABLE = spindle_en_r;
  assign FIELD_OUTPUT = field_drive_r;
  assign FIELD_ACTIVITY_INDICATOR = act_led_r;
  assign FIELD_FAULT_INDICATOR = (field_state_r == FLD_FAULT); // RQ10
  assign SERIAL_CHAN0_TRANSMIT = tx_r;
endmodule : servo_io_watchdog_encoder_mux

// ### tb/host_mux_model.sv
`timescale 1ns/100ps
module host_mux_model (
  // clock and reset
  clk,
  rst,
  // mux link
  sel,
  lines,
  even_q,
  odd_q
);
  import servo_io_pkg::*;
  input wire logic clk;
  input wire logic rst;
  output logic sel;
  input muxed_lines_t lines;
  output muxed_lines_t even_q;
  output muxed_lines_t odd_q;
  logic [1:0] ph_r;
  // four cycles a level, slow clock over 8, far below the 12 MHz ceiling
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ph_r <= 2'h0;
      sel <= 1'b0;
    end
    else
    begin
      ph_r <= ph_r + 2'h1;
      if (ph_r == 2'h3)
        sel <= ~sel;
    end
  end
  // one sample per level, taken late so the lines have settled
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      even_q <= '0;
      odd_q <= '0;
    end
    else if (ph_r == 2'h3)
    begin
      if (sel)
        odd_q <= lines;
      else
        even_q <= lines;
    end
  end
endmodule : host_mux_model

// ### tb/servo_io_chk.sv
`timescale 1ns/100ps
module servo_io_chk #(
  parameter int ANALOG_WDOG_CYCLES = 50
) (
  // clock
  input logic MCLK,
  input logic RESET,
  // bus
  input logic [7:0] ADDR,
  input logic [31:0] WDATA,
  input logic WR,
  input logic RD,
  input logic [31:0] RDATA,
  // drive
  input servo_io_pkg::cmd_bank_t ANALOG_COMMAND_OUTPUT,
  input logic [4:0] DRIVE_ENABLE_SWITCH,
  input logic SPINDLE_DRIVE_ENABLE,
  // encoder
  input servo_io_pkg::enc_lines_t ENCODER_POS,
  input servo_io_pkg::enc_lines_t ENCODER_NEG,
  input logic ENCODER_MUX_SELECT,
  input servo_io_pkg::muxed_lines_t MUXED_ENCODER,
  // field
  input logic [15:0] FIELD_OUTPUT,
  input logic FIELD_LOGIC_SUPPLY,
  input logic FIELD_ACTIVITY_INDICATOR,
  input logic FIELD_FAULT_INDICATOR,
  input logic SERIAL_CHAN0_RECEIVE,
  input logic SERIAL_CHAN0_TRANSMIT
);
  import servo_io_pkg::*;
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (RESET);
  logic kick;
  int idle_r;
  muxed_lines_t exp_r;
  logic exp_ok_r;
  assign kick = WR && (ADDR == OFS_CTRL || (ADDR >= OFS_CMD0 && ADDR <= OFS_CMD5 && ADDR[1:0] == 2'h0));
  // saturates so a long idle run cannot wrap
  always_ff @(posedge MCLK or posedge RESET)
  begin
    if (RESET)
      idle_r <= 0;
    else if (kick)
      idle_r <= 0;
    else if (idle_r < 100000)
      idle_r <= idle_r + 1;
  end
  always_ff @(posedge MCLK or posedge RESET)
  begin
    if (RESET)
    begin
      exp_r <= '0;
      exp_ok_r <= 1'b0;
    end
    else
    begin
      exp_ok_r <= (ENCODER_POS == ~ENCODER_NEG);
      for (int k = 0; k < N_PAIR; k++)
      begin
        exp_r.phase_a[k] <= ENCODER_POS.phase_a[2*k+ENCODER_MUX_SELECT];
        exp_r.phase_b[k] <= ENCODER_POS.phase_b[2*k+ENCODER_MUX_SELECT];
        exp_r.index[k] <= ENCODER_POS.index[2*k+ENCODER_MUX_SELECT];
      end
    end
  end
  sequence cmd0_write;
    WR && ADDR == OFS_CMD0;
  endsequence
  sequence ctrl_write;
    WR && ADDR == OFS_CTRL;
  endsequence
  chk_cmd_lands:
  assert property (cmd0_write |=> ##1 ANALOG_COMMAND_OUTPUT[0] == $past(WDATA[15:0], 2))
    else $error("command word not applied");
  chk_ctrl_lands:
  assert property (ctrl_write |=> ##1 DRIVE_ENABLE_SWITCH == {5{$past(WDATA[0], 2)}}
    && SPINDLE_DRIVE_ENABLE == $past(WDATA[1], 2))
    else $error("enable bits not applied");
  chk_enable_group:
  assert property (DRIVE_ENABLE_SWITCH == 5'h00 || DRIVE_ENABLE_SWITCH == 5'h1f)
    else $error("axis enables split");
  chk_wdog_safe:
  assert property (idle_r > ANALOG_WDOG_CYCLES + 2 |-> ANALOG_COMMAND_OUTPUT == '0
    && DRIVE_ENABLE_SWITCH == 5'h00 && !SPINDLE_DRIVE_ENABLE)
    else $error("drive live after silence");
  chk_power_safe:
  assert property ($fell(RESET) |-> ANALOG_COMMAND_OUTPUT == '0 && DRIVE_ENABLE_SWITCH == 5'h00)
    else $error("drive live at start");
  chk_fault_lit:
  assert property ($fell(RESET) |-> FIELD_FAULT_INDICATOR && !FIELD_ACTIVITY_INDICATOR)
    else $error("fault lamp dark at start");
  chk_rdata_idle:
  assert property (!RD |=> RDATA == 32'h0)
    else $error("read data outside slot");
  chk_mux_route:
  assert property (exp_ok_r |-> MUXED_ENCODER == exp_r)
    else $error("muxed line wrong");
  chk_dead_link:
  assert property (!FIELD_LOGIC_SUPPLY |=> SERIAL_CHAN0_TRANSMIT && FIELD_OUTPUT == 16'h0000)
    else $error("field alive without supply");
  chk_link_echo:
  assert property (FIELD_LOGIC_SUPPLY |=> SERIAL_CHAN0_TRANSMIT == $past(SERIAL_CHAN0_RECEIVE))
    else $error("link echo wrong");
  chk_fault_blocks:
  assert property (FIELD_FAULT_INDICATOR [*2] |-> FIELD_OUTPUT == 16'h0000)
    else $error("outputs on in fault");
endmodule : servo_io_chk
bind servo_io_watchdog_encoder_mux servo_io_chk #(.ANALOG_WDOG_CYCLES(ANALOG_WDOG_CYCLES)) servo_io_chk_i (
  .MCLK(MCLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
  .ANALOG_COMMAND_OUTPUT(ANALOG_COMMAND_OUTPUT), .DRIVE_ENABLE_SWITCH(DRIVE_ENABLE_SWITCH),
  .SPINDLE_DRIVE_ENABLE(SPINDLE_DRIVE_ENABLE), .ENCODER_POS(ENCODER_POS), .ENCODER_NEG(ENCODER_NEG),
  .ENCODER_MUX_SELECT(ENCODER_MUX_SELECT), .MUXED_ENCODER(MUXED_ENCODER), .FIELD_OUTPUT(FIELD_OUTPUT),
  .FIELD_LOGIC_SUPPLY(FIELD_LOGIC_SUPPLY), .FIELD_ACTIVITY_INDICATOR(FIELD_ACTIVITY_INDICATOR),
  .FIELD_FAULT_INDICATOR(FIELD_FAULT_INDICATOR), .SERIAL_CHAN0_RECEIVE(SERIAL_CHAN0_RECEIVE),
  .SERIAL_CHAN0_TRANSMIT(SERIAL_CHAN0_TRANSMIT));

// ### tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import servo_io_pkg::*;
  localparam int WD = 50;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wstb = 1'b0;
  logic rstb = 1'b0;
  logic [31:0] rdata;
  logic irq;
  cmd_bank_t analog_command_output;
  logic [4:0] den;
  logic spen;
  enc_lines_t epos = '0;
  enc_lines_t eneg = '1;
  logic msel;
  muxed_lines_t mux;
  muxed_lines_t even_q;
  muxed_lines_t odd_q;
  logic [31:0] fin = 32'h0;
  logic [15:0] fout;
  logic sup = 1'b1;
  logic slow = 1'b0;
  logic shigh = 1'b0;
  logic act;
  logic fault;
  logic srx = 1'b0;
  logic stx;
  int err_total = 0;
  int comparisons = 0;
  always #20 mclk = ~mclk;
  always @(posedge mclk) srx <= ~srx;
  servo_io_watchdog_encoder_mux #(.ANALOG_WDOG_CYCLES(WD), .FIELD_WDOG_CYCLES(WD)) servo_io_watchdog_encoder_mux_i (
    .MCLK(mclk), .RESET(reset), .ADDR(addr), .WDATA(wdata), .WR(wstb), .RD(rstb), .RDATA(rdata), .IRQ(irq),
    .ANALOG_COMMAND_OUTPUT(analog_command_output), .DRIVE_ENABLE_SWITCH(den), .SPINDLE_DRIVE_ENABLE(spen),
    .ENCODER_POS(epos), .ENCODER_NEG(eneg), .ENCODER_MUX_SELECT(msel), .MUXED_ENCODER(mux),
    .FIELD_INPUT(fin), .FIELD_OUTPUT(fout), .FIELD_LOGIC_SUPPLY(sup), .FIELD_SUPPLY_LOW(slow),
    .FIELD_SUPPLY_HIGH(shigh), .FIELD_ACTIVITY_INDICATOR(act), .FIELD_FAULT_INDICATOR(fault),
    .SERIAL_CHAN0_RECEIVE(srx), .SERIAL_CHAN0_TRANSMIT(stx));
  host_mux_model host_mux_model_i (.clk(mclk), .rst(reset), .sel(msel), .lines(mux), .even_q(even_q), .odd_q(odd_q));
  task automatic end_sim;
    $display("err_total %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  task automatic cmp(input logic [95:0] got, input logic [95:0] exp, input string m);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : cmp
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    wstb <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wstb <= 1'b0;
  endtask : wr_reg
  // data is looked at only in its single valid cycle
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e, input string m);
    @(posedge mclk);
    rstb <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rstb <= 1'b0;
    #1;
    cmp(rdata, e, m);
  endtask : rd_reg
  task automatic wait_fault(input logic v);
    repeat (100) if (fault !== v) cyc(1);
    cmp(fault, v, "fault lamp");
    if (fault !== v)
      end_sim();
  endtask : wait_fault
  function automatic muxed_lines_t pick(input enc_lines_t e, input int s);
    muxed_lines_t m;
    for (int k = 0; k < N_PAIR; k++)
    begin
      m.phase_a[k] = e.phase_a[2*k+s];
      m.phase_b[k] = e.phase_b[2*k+s];
      m.index[k] = e.index[2*k+s];
    end
    return m;
  endfunction : pick
  task automatic t_power;
    cmp({|analog_command_output, den, spen, fault, act}, 9'h002, "start state");
    rd_reg(OFS_STATUS, 32'h6, "status");
    rd_reg(OFS_IRQ_STATUS, 32'h0, "irq idle");
    rd_reg(8'hfc, 32'h0, "unmapped");
  endtask : t_power
  task automatic t_analog;
    cmd_bank_t v;
    v = {16'h7fff, 16'hffff, 16'h0001, 16'hedcc, 16'h1234, 16'h8000};
    for (int k = 0; k < N_AXIS; k++)
      wr_reg(OFS_CMD0 + 8'(4*k), {{16{v[k][15]}}, v[k]});
    wr_reg(OFS_CTRL, 32'h3);
    cyc(2);
    cmp(analog_command_output, v, "commands");
    cmp({den, spen}, 6'h3f, "all enabled");
    for (int k = 0; k < N_AXIS; k++)
      rd_reg(OFS_CMD0 + 8'(4*k), {{16{v[k][15]}}, v[k]}, "cmd back");
    wr_reg(OFS_CTRL, 32'h2);
    cyc(2);
    cmp({den, spen}, 6'h01, "spindle alone");
    wr_reg(OFS_CTRL, 32'h1);
    cyc(2);
    cmp({den, spen}, 6'h3e, "axes alone");
  endtask : t_analog
  task automatic t_wdog;
    cyc(WD - 15);
    cmp(den, 5'h1f, "early trip");
    cyc(25);
    cmp({|analog_command_output, den, spen}, 7'h00, "no trip");
    rd_reg(OFS_STATUS, 32'h6, "alive bit");
    rd_reg(OFS_IRQ_STATUS, 32'h1, "trip event");
    cmp(irq, 1'b0, "masked irq");
    wr_reg(OFS_IRQ_MASK, 32'h1);
    cyc(1);
    cmp(irq, 1'b1, "irq raised");
    wr_reg(OFS_IRQ_STATUS, 32'h1);
    cyc(1);
    cmp(irq, 1'b0, "irq cleared");
  endtask : t_wdog
  task automatic t_enc;
    enc_lines_t p;
    enc_lines_t q;
    enc_lines_t e;
    logic [5:0] md;
    for (int c = 0; c < 4; c++)
    begin
      p = c[0] ? 18'h2aa55 : 18'h15a96;
      md = (c < 2) ? 6'h3f : (c == 2) ? 6'h00 : 6'h15;
      q = (c == 0) ? ~p : (c == 1) ? ~p ^ 18'h0f00f : p;
      e.phase_a = p.phase_a & ~(q.phase_a & md);
      e.phase_b = p.phase_b & ~(q.phase_b & md);
      e.index = p.index & ~(q.index & md);
      wr_reg(OFS_ENC_MODE, {26'h0, md});
      @(posedge mclk);
      epos <= p;
      eneg <= q;
      cyc(20);
      cmp(even_q, pick(e, 0), "even encoders");
      cmp(odd_q, pick(e, 1), "odd encoders");
    end
  endtask : t_enc
  task automatic t_field;
    int flips;
    logic last;
    @(posedge mclk);
    fin <= 32'hc3a55a3c;
    wr_reg(OFS_FIELD_OUT, 32'hffff);
    cyc(2);
    cmp(fout, 16'h0, "update in fault");
    wr_reg(OFS_CTRL, 32'h4);
    wait_fault(1'b0);
    wr_reg(OFS_FIELD_OUT, 32'ha5c3);
    rd_reg(OFS_FIELD_IN, 32'hc3a55a3c, "inputs");
    cmp(fout, 16'ha5c3, "outputs");
    flips = 0;
    last = act;
    for (int n = 0; n < 1001; n++)
    begin
      if (n < 1000)
        rd_reg(OFS_FIELD_IN, 32'hc3a55a3c, "inputs");
      else
        cyc(3);
      flips += (act !== last);
      last = act;
    end
    cmp(flips, 2, "blink rate");
    cmp(fault, 1'b0, "lamp on in run");
    for (int s = 1; s < 3; s++)
    begin
      @(posedge mclk);
      {shigh, slow} <= 2'(s);
      wait_fault(1'b1);
      cyc(2);
      cmp(fout, 16'h0, "outputs in fault");
      wr_reg(OFS_CTRL, 32'h4);
      cyc(2);
      cmp(fault, 1'b1, "clear with cause");
      @(posedge mclk);
      {shigh, slow} <= 2'h0;
      wr_reg(OFS_FIELD_OUT, 32'h1234);
      wr_reg(OFS_CTRL, 32'h4);
      wait_fault(1'b0);
      cyc(2);
      cmp(fout, 16'ha5c3, "stale update");
    end
    cyc(WD + 20);
    wait_fault(1'b1);
    rd_reg(OFS_IRQ_STATUS, 32'h7, "events");
    @(posedge mclk);
    sup <= 1'b0;
    cyc(2);
    rd_reg(OFS_FIELD_IN, 32'h0, "no supply");
    cmp(stx, 1'b1, "link quiet");
  endtask : t_field
  initial
  begin
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    t_power();
    t_analog();
    t_wdog();
    t_enc();
    t_field();
    end_sim();
  end
  initial
  begin
    repeat (100000) @(posedge mclk);
    cmp(1'b0, 1'b1, "run too long");
    end_sim();
  end
endmodule : tb_top
